/* File: inc/status_bank_pkg.sv */
// shared constants, modes and carriers of the supply and thermal status bank
package status_bank_pkg;

    // ****************************************************************
    // register addresses (7-bit, as sent in the command byte)
    // ****************************************************************
    localparam logic [6:0] ADDR_SUPPLY_B = 7'h40;
    localparam logic [6:0] ADDR_SUPPLY_A = 7'h41;
    localparam logic [6:0] ADDR_THERMAL = 7'h42;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_BATTERY_UV = 6;
    localparam int BIT_EXT_OC = 4;
    localparam int BIT_EXT_UV = 3;
    localparam int BIT_EXT_OT = 2;
    localparam int BIT_MAIN_OV = 1;
    localparam int BIT_MAIN_PREWARN = 0;
    localparam int BIT_POWER_UP = 7;
    localparam int BIT_HS_UV = 6;
    localparam int BIT_HS_OV = 5;
    localparam int BIT_AUX_OT = 4;
    localparam int BIT_AUX_UV = 3;
    localparam int BIT_MAIN_SHORT = 2;
    localparam int BIT_MAIN_FAILSAFE = 1;
    localparam int BIT_MAIN_UV = 0;
    localparam int BIT_SHUTDOWN_L2 = 2;
    localparam int BIT_SHUTDOWN_L1 = 1;
    localparam int BIT_PREWARN_TEMP = 0;

    // ****************************************************************
    // implemented bits, reset values and bits kept on restart entry
    // ****************************************************************
    localparam logic [7:0] IMPL_SUPPLY_B = 8'h5F;
    localparam logic [7:0] IMPL_SUPPLY_A = 8'hFF;
    localparam logic [7:0] IMPL_THERMAL = 8'h07;
    localparam logic [7:0] POR_SUPPLY_B = 8'h00;
    localparam logic [7:0] POR_SUPPLY_A = 8'h80;
    localparam logic [7:0] POR_THERMAL = 8'h00;
    localparam logic [7:0] SOFT_SUPPLY_B = 8'h00;
    localparam logic [7:0] SOFT_SUPPLY_A = 8'h00;
    localparam logic [7:0] SOFT_THERMAL = 8'h00;
    localparam logic [7:0] KEEP_SUPPLY_B = 8'h5F;
    localparam logic [7:0] KEEP_SUPPLY_A = 8'hFD;
    localparam logic [7:0] KEEP_THERMAL = 8'h07;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int SHORT_TIME_US = 4000;
    localparam int SHORT_TIME_CYCLES = SHORT_TIME_US * CLK_MHZ;

    // ****************************************************************
    // device modes and short detector states
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_RESTART = 3'h6,
        MODE_FAILSAFE = 3'h7
    } device_mode_t;

    typedef enum logic [1:0] {
        SHORT_IDLE = 2'h0,
        SHORT_TIMING = 2'h1,
        SHORT_SEEN = 2'h3
    } short_state_t;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic clear;
    } status_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } status_rsp_t;

endpackage

/* File: src/sticky_status_byte.sv */
// one sticky read-and-clear status byte with reset, soft reset and restart handling
`timescale 1ns/10ps
module sticky_status_byte #(
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] POR_VALUE = 8'h00,
    parameter logic [7:0] SOFT_VALUE = 8'h00,
    parameter logic [7:0] KEEP_MASK = 8'hFF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] set_bits,
    input wire logic clear,
    input wire logic soft_reset,
    input wire logic restart_entry,
    output logic [7:0] value_r
);

    logic [7:0] base;
    logic [7:0] value_nxt;

    // restart forces the non-kept bits, clear drops all, set wins over both
    always_comb begin
        base = value_r;
        if (restart_entry) begin
            base = base & KEEP_MASK;
        end
        if (clear) begin
            base = 8'h00;
        end
        value_nxt = (base | set_bits) & IMPL_MASK;
    end

    // flags change only by events, restart, soft reset or an explicit clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            value_r <= POR_VALUE & IMPL_MASK;
        end else if (soft_reset) begin
            value_r <= SOFT_VALUE & IMPL_MASK;
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule

/* File: src/supply_thermal_status_bank.sv */
// supply and thermal sticky status registers behind the command port
`timescale 1ns/10ps

module supply_thermal_status_bank #(
    parameter int SHORT_CYCLES = status_bank_pkg::SHORT_TIME_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic soft_reset,
    input wire status_bank_pkg::device_mode_t device_mode,
    input wire logic reset_output,
    input wire logic main_reg_on,
    input wire logic battery_uv_det,
    input wire logic ext_oc_det,
    input wire logic ext_uv_det,
    input wire logic ext_ot_det,
    input wire logic main_ov_det,
    input wire logic main_prewarn_det,
    input wire logic main_below_reset_det,
    input wire logic main_uv_reset_event,
    input wire logic failsafe_uv4_event,
    input wire logic hs_uv_det,
    input wire logic hs_ov_det,
    input wire logic aux_ot_det,
    input wire logic aux_uv_det,
    input wire logic shutdown_l2_det,
    input wire logic shutdown_l1_det,
    input wire logic temp_prewarn_det,
    input wire status_bank_pkg::status_req_t req,
    output status_bank_pkg::status_rsp_t rsp_r,
    output logic thermal_failsafe_req_r,
    output logic [7:0] supply_fault_status_b_r,
    output logic [7:0] supply_fault_status_a_r,
    output logic [7:0] thermal_fault_status_r
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    localparam int CNT_W = $clog2(SHORT_CYCLES + 1);

    generate
        if (SHORT_CYCLES < 2) begin : g_bad_short
            $error("SHORT_CYCLES must be at least 2");
        end
    endgenerate

    // ****************************************************************
    // mode tracking
    // ****************************************************************
    status_bank_pkg::device_mode_t mode_prev_r;
    logic reset_out_seen_r;
    logic restart_entry;
    logic sleep_main_off;

    // restart is acted on once, at the cycle the mode changes into it
    assign restart_entry = (device_mode == status_bank_pkg::MODE_RESTART) &&
                           (mode_prev_r != status_bank_pkg::MODE_RESTART);
    assign sleep_main_off = (device_mode == status_bank_pkg::MODE_SLEEP) && !main_reg_on;

    // previous mode for entry detection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_prev_r <= status_bank_pkg::MODE_INIT;
        end else begin
            mode_prev_r <= device_mode;
        end
    end

    // remembers the first reset output release inside init mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_out_seen_r <= 1'b0;
        end else if (device_mode != status_bank_pkg::MODE_INIT) begin
            reset_out_seen_r <= 1'b0;
        end else if (reset_output) begin
            reset_out_seen_r <= 1'b1;
        end
    end

    // ****************************************************************
    // main regulator short-to-ground timer
    // ****************************************************************
    status_bank_pkg::short_state_t short_state_r;
    status_bank_pkg::short_state_t short_state_nxt;
    logic [CNT_W-1:0] short_cnt_r;
    logic short_expire;
    logic short_cond;

    assign short_expire = (short_cnt_r == CNT_W'(SHORT_CYCLES - 1));
    assign short_cond = (short_state_r == status_bank_pkg::SHORT_SEEN);

    // low output while switched on must persist for the full window
    always_comb begin
        short_state_nxt = short_state_r;
        case (short_state_r)
            status_bank_pkg::SHORT_IDLE: begin
                if (main_reg_on && main_below_reset_det) begin
                    short_state_nxt = status_bank_pkg::SHORT_TIMING;
                end
            end
            status_bank_pkg::SHORT_TIMING: begin
                if (!main_reg_on || !main_below_reset_det) begin
                    short_state_nxt = status_bank_pkg::SHORT_IDLE;
                end else if (short_expire) begin
                    short_state_nxt = status_bank_pkg::SHORT_SEEN;
                end
            end
            status_bank_pkg::SHORT_SEEN: begin
                if (!main_reg_on || !main_below_reset_det) begin
                    short_state_nxt = status_bank_pkg::SHORT_IDLE;
                end
            end
            default: begin
                short_state_nxt = status_bank_pkg::SHORT_IDLE;
            end
        endcase
    end

    // short detector state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            short_state_r <= status_bank_pkg::SHORT_IDLE;
        end else begin
            short_state_r <= short_state_nxt;
        end
    end

    // window counter, runs only while timing
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            short_cnt_r <= '0;
        end else if (short_state_r == status_bank_pkg::SHORT_TIMING &&
                     short_state_nxt == status_bank_pkg::SHORT_TIMING) begin
            short_cnt_r <= short_cnt_r + CNT_W'(1);
        end else begin
            short_cnt_r <= '0;
        end
    end

    // ****************************************************************
    // set sources
    // ****************************************************************
    logic uv_update_ok;
    logic [7:0] set_supply_b;
    logic [7:0] set_supply_a;
    logic [7:0] set_thermal;

    // undervoltage flag may only update in these situations
    always_comb begin
        case (device_mode)
            status_bank_pkg::MODE_NORMAL: uv_update_ok = 1'b1;
            status_bank_pkg::MODE_STOP: uv_update_ok = 1'b1;
            status_bank_pkg::MODE_INIT: uv_update_ok = reset_out_seen_r;
            status_bank_pkg::MODE_SLEEP: uv_update_ok = 1'b1;
            status_bank_pkg::MODE_RESTART: uv_update_ok = 1'b0;
            default: uv_update_ok = 1'b0;
        endcase
        if (short_cond) begin
            uv_update_ok = 1'b1;
        end
        if (sleep_main_off) begin
            uv_update_ok = 1'b0;
        end
    end

    // first supply register events, detector levels re-set after clear
    always_comb begin
        set_supply_b = 8'h00;
        set_supply_b[status_bank_pkg::BIT_BATTERY_UV] = battery_uv_det;
        set_supply_b[status_bank_pkg::BIT_EXT_OC] = ext_oc_det;
        set_supply_b[status_bank_pkg::BIT_EXT_UV] = ext_uv_det;
        set_supply_b[status_bank_pkg::BIT_EXT_OT] = ext_ot_det;
        set_supply_b[status_bank_pkg::BIT_MAIN_OV] = main_ov_det && !sleep_main_off;
        set_supply_b[status_bank_pkg::BIT_MAIN_PREWARN] = main_prewarn_det;
    end

    // second supply register events
    always_comb begin
        set_supply_a = 8'h00;
        set_supply_a[status_bank_pkg::BIT_HS_UV] = hs_uv_det;
        set_supply_a[status_bank_pkg::BIT_HS_OV] = hs_ov_det;
        set_supply_a[status_bank_pkg::BIT_AUX_OT] = aux_ot_det;
        set_supply_a[status_bank_pkg::BIT_AUX_UV] = aux_uv_det;
        set_supply_a[status_bank_pkg::BIT_MAIN_SHORT] = short_cond && !sleep_main_off;
        set_supply_a[status_bank_pkg::BIT_MAIN_FAILSAFE] = failsafe_uv4_event;
        set_supply_a[status_bank_pkg::BIT_MAIN_UV] = main_uv_reset_event && uv_update_ok;
    end

    // thermal register events
    always_comb begin
        set_thermal = 8'h00;
        set_thermal[status_bank_pkg::BIT_SHUTDOWN_L2] = shutdown_l2_det;
        set_thermal[status_bank_pkg::BIT_SHUTDOWN_L1] = shutdown_l1_det;
        set_thermal[status_bank_pkg::BIT_PREWARN_TEMP] = temp_prewarn_det;
    end

    // ****************************************************************
    // command decode
    // ****************************************************************
    logic clr_supply_b;
    logic clr_supply_a;
    logic clr_thermal;

    // access bit high means read, then clear the addressed byte
    assign clr_supply_b = req.valid && req.clear &&
                          (req.addr == status_bank_pkg::ADDR_SUPPLY_B);
    assign clr_supply_a = req.valid && req.clear &&
                          (req.addr == status_bank_pkg::ADDR_SUPPLY_A);
    assign clr_thermal = req.valid && req.clear &&
                         (req.addr == status_bank_pkg::ADDR_THERMAL);

    // ****************************************************************
    // status registers
    // ****************************************************************
    // first supply register, restart drops bits 7 and 5
    sticky_status_byte #(
        .IMPL_MASK(status_bank_pkg::IMPL_SUPPLY_B),
        .POR_VALUE(status_bank_pkg::POR_SUPPLY_B),
        .SOFT_VALUE(status_bank_pkg::SOFT_SUPPLY_B),
        .KEEP_MASK(status_bank_pkg::KEEP_SUPPLY_B)
    ) u_supply_b (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_bits(set_supply_b),
        .clear(clr_supply_b),
        .soft_reset(soft_reset),
        .restart_entry(restart_entry),
        .value_r(supply_fault_status_b_r)
    );

    // second supply register, power-up bit set only by power-on reset
    sticky_status_byte #(
        .IMPL_MASK(status_bank_pkg::IMPL_SUPPLY_A),
        .POR_VALUE(status_bank_pkg::POR_SUPPLY_A),
        .SOFT_VALUE(status_bank_pkg::SOFT_SUPPLY_A),
        .KEEP_MASK(status_bank_pkg::KEEP_SUPPLY_A)
    ) u_supply_a (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_bits(set_supply_a),
        .clear(clr_supply_a),
        .soft_reset(soft_reset),
        .restart_entry(restart_entry),
        .value_r(supply_fault_status_a_r)
    );

    // thermal register, restart drops bits 7 to 3
    sticky_status_byte #(
        .IMPL_MASK(status_bank_pkg::IMPL_THERMAL),
        .POR_VALUE(status_bank_pkg::POR_THERMAL),
        .SOFT_VALUE(status_bank_pkg::SOFT_THERMAL),
        .KEEP_MASK(status_bank_pkg::KEEP_THERMAL)
    ) u_thermal (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_bits(set_thermal),
        .clear(clr_thermal),
        .soft_reset(soft_reset),
        .restart_entry(restart_entry),
        .value_r(thermal_fault_status_r)
    );

    // ****************************************************************
    // read answer and fail-safe request
    // ****************************************************************
    logic [7:0] read_mux;

    // answer carries the value held before any clear of the same command
    always_comb begin
        case (req.addr)
            status_bank_pkg::ADDR_SUPPLY_B: read_mux = supply_fault_status_b_r;
            status_bank_pkg::ADDR_SUPPLY_A: read_mux = supply_fault_status_a_r;
            status_bank_pkg::ADDR_THERMAL: read_mux = thermal_fault_status_r;
            default: read_mux = status_bank_pkg::UNMAPPED_DATA;
        endcase
    end

    // answer one cycle after each request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= req.valid;
            rsp_r.data <= req.valid ? read_mux : 8'h00;
        end
    end

    // severe thermal shutdown flag asks for fail-safe mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            thermal_failsafe_req_r <= 1'b0;
        end else begin
            thermal_failsafe_req_r <= thermal_fault_status_r[status_bank_pkg::BIT_SHUTDOWN_L2];
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        ((supply_fault_status_b_r & ~status_bank_pkg::IMPL_SUPPLY_B) == 8'h00) &&
        ((thermal_fault_status_r & ~status_bank_pkg::IMPL_THERMAL) == 8'h00))
        else $error("reserved status bit set");

    a_read_thermal: assert property (@(posedge core_clk) disable iff (!reset_n)
        (req.valid && req.addr == status_bank_pkg::ADDR_THERMAL) |=>
        (rsp_r.valid && rsp_r.data == $past(thermal_fault_status_r)))
        else $error("thermal read answer wrong");

    a_clear_thermal: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clr_thermal && !shutdown_l2_det && !shutdown_l1_det && !temp_prewarn_det) |=>
        (thermal_fault_status_r == 8'h00))
        else $error("thermal clear had no effect");

    a_sticky_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!clr_thermal && !soft_reset && !restart_entry) |=>
        ((thermal_fault_status_r & $past(thermal_fault_status_r)) ==
         $past(thermal_fault_status_r)))
        else $error("thermal flag dropped without clear");

    a_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clr_supply_a && hs_uv_det && !soft_reset) |=>
        supply_fault_status_a_r[status_bank_pkg::BIT_HS_UV])
        else $error("event lost on clear");

    a_restart_fs: assert property (@(posedge core_clk) disable iff (!reset_n)
        (restart_entry && !failsafe_uv4_event && !soft_reset) |=>
        !supply_fault_status_a_r[status_bank_pkg::BIT_MAIN_FAILSAFE])
        else $error("restart kept fail-safe entry flag");

    a_short_window: assert property (@(posedge core_clk) disable iff (!reset_n)
        (short_state_r == status_bank_pkg::SHORT_SEEN && !$past(short_cond)) |->
        ($past(short_cnt_r) == CNT_W'(SHORT_CYCLES - 1)))
        else $error("short seen before window elapsed");

    a_sleep_block: assert property (@(posedge core_clk) disable iff (!reset_n)
        (sleep_main_off && !soft_reset) |=>
        !$rose(supply_fault_status_a_r[status_bank_pkg::BIT_MAIN_UV]) &&
        !$rose(supply_fault_status_b_r[status_bank_pkg::BIT_MAIN_OV]))
        else $error("main flag set in sleep with regulator off");

    a_uv_restart: assert property (@(posedge core_clk) disable iff (!reset_n)
        (device_mode == status_bank_pkg::MODE_RESTART && !short_cond) |=>
        !$rose(supply_fault_status_a_r[status_bank_pkg::BIT_MAIN_UV]))
        else $error("undervoltage flag updated in restart");

    a_soft_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        soft_reset |=> (supply_fault_status_a_r == 8'h00) &&
        (supply_fault_status_b_r == 8'h00) && (thermal_fault_status_r == 8'h00))
        else $error("soft reset did not clear status");

    a_failsafe_req: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(thermal_fault_status_r[status_bank_pkg::BIT_SHUTDOWN_L2]) |=>
        thermal_failsafe_req_r)
        else $error("severe shutdown did not request fail-safe");

endmodule

/* File: verification/status_host_model.sv */
// host model that issues status commands and collects the answers
`timescale 1ns/10ps
module status_host_model (
    input wire logic core_clk,
    input wire status_bank_pkg::status_rsp_t rsp_r,
    output status_bank_pkg::status_req_t req
);
    // idle command port until the first transfer
    initial req = '0;
    // one command: address with access bit, answer taken one edge later
    task automatic xfer(input logic [6:0] a, input logic c, output logic [8:0] r);
        @(posedge core_clk);
        req <= '{valid: 1'b1, addr: a, clear: c};
        @(posedge core_clk);
        req <= '0;
        #1 r = rsp_r;
    endtask
endmodule

/* File: verification/tb_top.sv */
// bench for the supply and thermal status bank
`timescale 1ns/10ps
module tb_top;
    logic core_clk, reset_n, soft_reset, main_reg_on, reset_output, fs_req;
    logic [7:0] lvl_b, lvl_a, lvl_t;
    logic [15:0] d;
    logic [8:0] r;
    int errors, n_checks;
    status_bank_pkg::device_mode_t device_mode;
    status_bank_pkg::status_req_t req;
    status_bank_pkg::status_rsp_t rsp_r;
    supply_thermal_status_bank #(.SHORT_CYCLES(16)) supply_thermal_status_bank_inst (
        .core_clk, .reset_n, .soft_reset, .device_mode, .reset_output, .main_reg_on,
        .battery_uv_det(d[0]), .ext_oc_det(d[1]), .ext_uv_det(d[2]), .ext_ot_det(d[3]),
        .main_ov_det(d[4]), .main_prewarn_det(d[5]), .main_below_reset_det(d[6]),
        .main_uv_reset_event(d[7]), .failsafe_uv4_event(d[8]), .hs_uv_det(d[9]),
        .hs_ov_det(d[10]), .aux_ot_det(d[11]), .aux_uv_det(d[12]),
        .shutdown_l2_det(d[13]), .shutdown_l1_det(d[14]), .temp_prewarn_det(d[15]),
        .req, .rsp_r, .thermal_failsafe_req_r(fs_req), .supply_fault_status_b_r(lvl_b),
        .supply_fault_status_a_r(lvl_a), .thermal_fault_status_r(lvl_t));
    status_host_model status_host_model_inst (.core_clk, .rsp_r, .req);
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    // one command and comparison of the answered byte
    task automatic chk(input logic [6:0] a, input logic c, input logic [7:0] e);
        status_host_model_inst.xfer(a, c, r);
        n_checks++;
        if (r !== {1'b1, e}) begin
            errors++;
            $display("unexpected at %0t: addr %h got %h want %h", $time, a, r, e);
        end
    endtask
    // comparison of a level output of the design
    task automatic chk_lvl(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: level got %h want %h", $time, g, e);
        end
    endtask
    // one-cycle pulse on the selected detectors
    task automatic pulse(input logic [15:0] m);
        @(posedge core_clk);
        d <= m;
        @(posedge core_clk);
        d <= '0;
    endtask
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // watchdog against a hang
    initial begin
        #50000;
        errors++;
        end_of_test();
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        soft_reset = 1'b0;
        main_reg_on = 1'b1;
        reset_output = 1'b0;
        d = '0;
        device_mode = status_bank_pkg::MODE_NORMAL;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        chk(7'h40, 0, 8'h00);
        chk_lvl(lvl_a, 8'h80);
        chk(7'h41, 1, 8'h80);
        chk(7'h41, 0, 8'h00);
        chk(7'h42, 0, 8'h00);
        chk(7'h43, 0, 8'h00);
        $display("reset values done");
        pulse(16'hFFBF);
        chk(7'h40, 0, 8'h5F);
        chk(7'h41, 0, 8'h7B);
        chk(7'h42, 0, 8'h07);
        chk_lvl(lvl_b, 8'h5F);
        chk_lvl(lvl_a, 8'h7B);
        chk_lvl(lvl_t, 8'h07);
        chk_lvl({7'h00, fs_req}, 8'h01);
        @(posedge core_clk) device_mode <= status_bank_pkg::MODE_RESTART;
        repeat (2) @(posedge core_clk);
        chk(7'h41, 1, 8'h79);
        chk(7'h40, 0, 8'h5F);
        chk(7'h42, 1, 8'h07);
        pulse(16'h0080);
        chk(7'h41, 0, 8'h00);
        chk_lvl({7'h00, fs_req}, 8'h00);
        @(posedge core_clk) device_mode <= status_bank_pkg::MODE_NORMAL;
        repeat (2) @(posedge core_clk);
        pulse(16'h0080);
        chk(7'h41, 1, 8'h01);
        $display("flags and restart done");
        @(posedge core_clk) device_mode <= status_bank_pkg::MODE_FAILSAFE;
        pulse(16'h0080);
        chk(7'h41, 0, 8'h00);
        @(posedge core_clk) device_mode <= status_bank_pkg::MODE_INIT;
        pulse(16'h0080);
        chk(7'h41, 0, 8'h00);
        @(posedge core_clk) reset_output <= 1'b1;
        pulse(16'h0080);
        chk(7'h41, 1, 8'h01);
        @(posedge core_clk) device_mode <= status_bank_pkg::MODE_STOP;
        pulse(16'h0080);
        chk(7'h41, 1, 8'h01);
        $display("mode gating done");
        @(posedge core_clk) d <= 16'h0201;
        chk(7'h40, 1, 8'h5F);
        chk(7'h40, 0, 8'h40);
        chk(7'h41, 1, 8'h40);
        @(posedge core_clk) d <= '0;
        chk(7'h40, 1, 8'h40);
        chk(7'h41, 1, 8'h40);
        @(posedge core_clk);
        device_mode <= status_bank_pkg::MODE_SLEEP;
        main_reg_on <= 1'b0;
        pulse(16'h00D0);
        chk(7'h40, 0, 8'h00);
        chk(7'h41, 0, 8'h00);
        @(posedge core_clk) main_reg_on <= 1'b1;
        @(posedge core_clk) d <= 16'h0040;
        repeat (20) @(posedge core_clk);
        d <= '0;
        chk(7'h41, 1, 8'h04);
        $display("clear, sleep and short done");
        pulse(16'hFFBF);
        @(posedge core_clk) soft_reset <= 1'b1;
        @(posedge core_clk) soft_reset <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            chk(7'(8'h40 + i), 0, 8'h00);
        end
        $display("soft reset done");
        end_of_test();
    end
endmodule
